// ### rtl/srg_pkg.sv
// Summary of operation
// (R1) rise time sets 100% rise, 0.1..600 s
// (R2) fall time sets 100% fall, same range
// (R3) freeze holds output at last value
// (R4) any ramp reset overrides freeze
// (R5) invert negates target before rate limiting
// (R6) curve fraction sets S-shaped share; zero linear; code: nonzero curve shapes only the start, fixed step/32 build-up
// (R7) effective time = time*(3.5*curve/100+1)
// (R8) slewing limit 0..100% decides ramp activity
// (R9) slewing flag when |output-target| exceeds limit
// (R10) slewing flag means ramp is limiting rate
// (R11) restart select resets ramp on start pulse
// (R12) sequencer pulses start one cycle per enable
// (R13) restart select preloads output at each enable
// (R14) no preload when drive is disabled
// (R15) forced preload holds output at preload level
// (R16) forced preload independent of restart select
// (R17) after forced preload, slew from preload value
// (R18) after freeze release, ramp from held value
// (R19) target steps are slewed, never jumped
// (R20) rise rate away from zero, fall toward
// (R21) per tick step bounded, stop exactly on target
package srg_pkg;
  // register byte offsets
  localparam logic [7:0] SRG_OFF_CTRL = 8'h00;
  localparam logic [7:0] SRG_OFF_RISE = 8'h04;
  localparam logic [7:0] SRG_OFF_FALL = 8'h08;
  localparam logic [7:0] SRG_OFF_CURVE = 8'h0c;
  localparam logic [7:0] SRG_OFF_LIMIT = 8'h10;
  localparam logic [7:0] SRG_OFF_PRELOAD = 8'h14;
  localparam logic [7:0] SRG_OFF_STATUS = 8'h18;
  localparam logic [7:0] SRG_OFF_OUTPUT = 8'h1c;
  // control field positions
  localparam int SRG_CTRL_INVERT = 0;
  localparam int SRG_CTRL_RESTART_SEL = 1;
  localparam int SRG_CTRL_FORCED = 2;
  localparam int SRG_CTRL_FREEZE = 3;
  // reset values: times in 0.1 s, percents in 0.01 %
  localparam logic [3:0] SRG_CTRL_RST = 4'h2;
  localparam logic [12:0] SRG_RISE_RST = 13'h0064;
  localparam logic [12:0] SRG_FALL_RST = 13'h0064;
  localparam logic [13:0] SRG_CURVE_RST = 14'h00fa;
  localparam logic [13:0] SRG_LIMIT_RST = 14'h0032;
  localparam logic [15:0] SRG_PRELOAD_RST = 16'h0000;
  // setting limits
  localparam logic [12:0] SRG_TIME_MIN = 13'h0001;
  localparam logic [12:0] SRG_TIME_MAX = 13'h1770;
  localparam logic [13:0] SRG_PCT_MAX = 14'h2710;
  // curve scaling: denominator = time * (20000 + 7 * curve)
  localparam logic [31:0] SRG_CURVE_BASE = 32'h00004e20;
  localparam logic [31:0] SRG_CURVE_MUL = 32'h00000007;
  // control tick timing
  localparam int SRG_CLK_HZ = 40_000_000;
  localparam int SRG_TICK_US = 1000;
  localparam int SRG_TICK_CYCLES = SRG_CLK_HZ / 1_000_000 * SRG_TICK_US;
  // step numerator: 100 % (16.16 fixed) * 20000 / ticks per 0.1 s
  localparam longint SRG_STEP_NUM_L = 64'd10000 * 64'd65536 * 64'd20000 * SRG_TICK_US / 64'd100000;
  localparam logic [39:0] SRG_STEP_NUM = SRG_STEP_NUM_L[39:0];
  // s-curve rate build-up, step/32 per tick
  localparam int SRG_JERK_SHIFT = 5;
  localparam logic [1:0] SRG_RESP_OKAY = 2'h0;
  localparam logic [1:0] SRG_RESP_SLVERR = 2'h2;
endpackage

// ### rtl/srg_divider.sv
`timescale 1ns/1ps
module srg_divider import srg_pkg::*; #(
  parameter int NW = 40,
  parameter int DW = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [NW-1:0] numer,
  input wire logic [DW-1:0] denom,
  // answer
  output logic busy,
  output logic done,
  output logic [NW-1:0] quot
);
  logic [DW:0] rem_q;
  logic [DW:0] rem_sh;
  logic [DW-1:0] den_q;
  logic [NW-1:0] quo_q;
  logic [$clog2(NW+1)-1:0] cnt_q;
  logic run_q;
  logic done_q;

  assign rem_sh = {rem_q[DW-1:0], quo_q[NW-1]};

  // restoring division, one quotient bit a clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_q <= '0;
      den_q <= '0;
      quo_q <= '0;
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !run_q) begin
        rem_q <= '0;
        den_q <= denom;
        quo_q <= numer;
        cnt_q <= ($clog2(NW+1))'(NW);
        run_q <= 1'b1;
      end else if (run_q) begin
        if (rem_sh >= {1'b0, den_q}) begin
          rem_q <= rem_sh - {1'b0, den_q};
          quo_q <= {quo_q[NW-2:0], 1'b1};
        end else begin
          rem_q <= rem_sh;
          quo_q <= {quo_q[NW-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == 1) begin
          run_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign busy = run_q;
  assign done = done_q;
  assign quot = quo_q;
endmodule

// ### rtl/srg_top.sv
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module srg_top import srg_pkg::*; #(
  parameter int TICK_CYCLES = SRG_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // setpoint side
  input wire logic [15:0] target_setpoint,
  input wire logic start_pulse,
  input wire logic digital_input_two,
  output logic [15:0] shaped_setpoint,
  output logic slewing_flag
);
  typedef enum {SRG_RISE_GO, SRG_RISE_WAIT, SRG_FALL_GO, SRG_FALL_WAIT} srg_div_st_t;

  logic rst_meta_q;
  logic rst_sync_q;
  logic [3:0] ctrl_q;
  logic [12:0] rise_q;
  logic [12:0] fall_q;
  logic [13:0] curve_q;
  logic [13:0] limit_q;
  logic [15:0] preload_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [$clog2(TICK_CYCLES)-1:0] tick_cnt_q;
  logic tick_q;
  srg_div_st_t div_st_q;
  logic div_start;
  logic div_busy;
  logic div_done;
  logic [39:0] div_quot;
  logic [31:0] step_rise_q;
  logic [31:0] step_fall_q;
  logic [31:0] rate_q;
  logic signed [31:0] pos_q;
  logic slew_q;
  logic wr_fire;

  // reset is released through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  function automatic logic [31:0] srg_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic srg_mapped(input logic [7:0] addr);
    return addr[1:0] == 2'b00 && addr <= SRG_OFF_OUTPUT;
  endfunction

  // write channel: address and data taken in either order
  // readies stay low until the internal reset lifts, so no early request is lost
  assign s_axi_awready = rst_sync_q && !aw_got_q && !bvalid_q;
  assign s_axi_wready = rst_sync_q && !w_got_q && !bvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= SRG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= srg_mapped(awaddr_q) ? SRG_RESP_OKAY : SRG_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // settings; out-of-range times and percents are clamped on write
  always_ff @(posedge clk or negedge rst_sync_q) begin
    logic [31:0] v;
    if (!rst_sync_q) begin
      ctrl_q <= SRG_CTRL_RST;
      rise_q <= SRG_RISE_RST;
      fall_q <= SRG_FALL_RST;
      curve_q <= SRG_CURVE_RST;
      limit_q <= SRG_LIMIT_RST;
      preload_q <= SRG_PRELOAD_RST;
    end else if (wr_fire) begin
      if (awaddr_q == SRG_OFF_CTRL) begin
        v = srg_merge({28'h0, ctrl_q}, wdata_q, wstrb_q);
        ctrl_q <= v[3:0];
      end else if (awaddr_q == SRG_OFF_RISE || awaddr_q == SRG_OFF_FALL) begin
        v = srg_merge({19'h0, awaddr_q == SRG_OFF_RISE ? rise_q : fall_q}, wdata_q, wstrb_q);
        if (v < {19'h0, SRG_TIME_MIN}) begin
          v = {19'h0, SRG_TIME_MIN};
        end else if (v > {19'h0, SRG_TIME_MAX}) begin
          v = {19'h0, SRG_TIME_MAX};
        end
        if (awaddr_q == SRG_OFF_RISE) begin
          rise_q <= v[12:0]; // (R1)
        end else begin
          fall_q <= v[12:0]; // (R2)
        end
      end else if (awaddr_q == SRG_OFF_CURVE) begin
        v = srg_merge({18'h0, curve_q}, wdata_q, wstrb_q);
        curve_q <= v > {18'h0, SRG_PCT_MAX} ? SRG_PCT_MAX : v[13:0]; // (R6)
      end else if (awaddr_q == SRG_OFF_LIMIT) begin
        v = srg_merge({18'h0, limit_q}, wdata_q, wstrb_q);
        limit_q <= v > {18'h0, SRG_PCT_MAX} ? SRG_PCT_MAX : v[13:0]; // (R8)
      end else if (awaddr_q == SRG_OFF_PRELOAD) begin
        v = srg_merge({16'h0, preload_q}, wdata_q, wstrb_q);
        preload_q <= v[15:0];
      end
    end else begin
      v = '0;
    end
  end

  // read channel, one word answered the cycle after the address
  assign s_axi_arready = rst_sync_q && !rvalid_q;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= SRG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= SRG_RESP_OKAY;
      if (s_axi_araddr == SRG_OFF_CTRL) begin
        rdata_q <= {28'h0, ctrl_q};
      end else if (s_axi_araddr == SRG_OFF_RISE) begin
        rdata_q <= {19'h0, rise_q};
      end else if (s_axi_araddr == SRG_OFF_FALL) begin
        rdata_q <= {19'h0, fall_q};
      end else if (s_axi_araddr == SRG_OFF_CURVE) begin
        rdata_q <= {18'h0, curve_q};
      end else if (s_axi_araddr == SRG_OFF_LIMIT) begin
        rdata_q <= {18'h0, limit_q};
      end else if (s_axi_araddr == SRG_OFF_PRELOAD) begin
        rdata_q <= {16'h0, preload_q};
      end else if (s_axi_araddr == SRG_OFF_STATUS) begin
        rdata_q <= {30'h0, rate_q != 32'h0, slew_q};
      end else if (s_axi_araddr == SRG_OFF_OUTPUT) begin
        rdata_q <= {{16{pos_q[31]}}, pos_q[31:16]};
      end else begin
        rdata_q <= '0;
        rresp_q <= SRG_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // control tick enable
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // step sizes recomputed continually; a settings change lands within a few hundred clocks
  logic [12:0] div_time;
  logic [31:0] div_den;
  assign div_time = (div_st_q == SRG_RISE_GO || div_st_q == SRG_RISE_WAIT) ? rise_q : fall_q;
  assign div_den = 32'(div_time) * (SRG_CURVE_BASE + SRG_CURVE_MUL * 32'(curve_q)); // (R7)
  assign div_start = (div_st_q == SRG_RISE_GO || div_st_q == SRG_FALL_GO) && !div_busy;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      div_st_q <= SRG_RISE_GO;
      step_rise_q <= '0;
      step_fall_q <= '0;
    end else begin
      case (div_st_q)
        SRG_RISE_GO: begin
          if (div_start) begin
            div_st_q <= SRG_RISE_WAIT;
          end
        end
        SRG_RISE_WAIT: begin
          if (div_done) begin
            step_rise_q <= div_quot[31:0]; // (R1)
            div_st_q <= SRG_FALL_GO;
          end
        end
        SRG_FALL_GO: begin
          if (div_start) begin
            div_st_q <= SRG_FALL_WAIT;
          end
        end
        default: begin
          if (div_done) begin
            step_fall_q <= div_quot[31:0]; // (R2)
            div_st_q <= SRG_RISE_GO;
          end
        end
      endcase
    end
  end

  srg_divider #(.NW(40), .DW(32)) u_div (
    .clk(clk),
    .rst_n(rst_sync_q),
    .start(div_start),
    .numer(SRG_STEP_NUM),
    .denom(div_den),
    .busy(div_busy),
    .done(div_done),
    .quot(div_quot)
  );

  // ramp target, 16.16 fixed point in hundredths of a percent
  logic signed [16:0] tgt_w;
  logic signed [32:0] tgt_fx;
  logic signed [32:0] diff;
  logic [32:0] diff_abs;
  logic away;
  logic [31:0] lin_step;
  logic [31:0] rate_nx;
  logic [31:0] eff_step;
  logic preload_now;
  logic freeze;

  assign tgt_w = ctrl_q[SRG_CTRL_INVERT] ? -$signed({target_setpoint[15], target_setpoint})
                                         : $signed({target_setpoint[15], target_setpoint}); // (R5)
  assign tgt_fx = {tgt_w, 16'h0};
  assign diff = tgt_fx - {pos_q[31], pos_q};
  assign diff_abs = diff[32] ? 33'(-diff) : diff;
  assign away = diff[32] ? pos_q[31] || pos_q == 0 : !pos_q[31]; // (R20)
  assign lin_step = away ? step_rise_q : step_fall_q; // (R20)
  // s-curve trade-off: only the rate build-up is shaped, the stop is a clean clamp
  assign rate_nx = rate_q + (lin_step >> SRG_JERK_SHIFT) + 32'h1;
  assign eff_step = curve_q == 0 ? lin_step : (rate_nx > lin_step ? lin_step : rate_nx); // (R6)
  assign preload_now = ctrl_q[SRG_CTRL_FORCED] // (R15) (R16)
                       || (ctrl_q[SRG_CTRL_RESTART_SEL] && start_pulse); // (R11) (R13) (R14)
  assign freeze = ctrl_q[SRG_CTRL_FREEZE] || digital_input_two;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      pos_q <= '0;
      rate_q <= '0;
    end else if (preload_now) begin
      pos_q <= {preload_q, 16'h0}; // (R4) (R13) (R15)
      rate_q <= '0;
    end else if (tick_q && !freeze) begin // (R3) (R17) (R18)
      if (diff_abs <= {1'b0, eff_step}) begin
        pos_q <= tgt_fx[31:0]; // (R21)
        rate_q <= '0;
      end else if (diff[32]) begin
        pos_q <= pos_q - $signed(eff_step); // (R19) (R21)
        rate_q <= eff_step;
      end else begin
        pos_q <= pos_q + $signed(eff_step); // (R19) (R21)
        rate_q <= eff_step;
      end
    end
  end

  // slewing flag from the whole-hundredths difference
  logic signed [17:0] out_diff;
  logic [17:0] out_abs;
  // the integer part is a plain slice, so it must be re-signed before widening
  assign out_diff = 18'($signed(pos_q[31:16])) - 18'(tgt_w);
  assign out_abs = out_diff[17] ? 18'(-out_diff) : out_diff;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      slew_q <= 1'b0;
    end else begin
      slew_q <= out_abs > {4'h0, limit_q}; // (R8) (R9) (R10)
    end
  end

  assign shaped_setpoint = pos_q[31:16];
  assign slewing_flag = slew_q;
endmodule

// ### test/srg_top_sva.sv
`timescale 1ns/1ps
module srg_top_sva import srg_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // setpoint side
  input wire logic start_pulse,
  input wire logic digital_input_two,
  input wire logic [15:0] shaped_setpoint
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic aw_bad_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_bad_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_bad_q <= (s_axi_awaddr > 8'h1c) || (s_axi_awaddr[1:0] != 2'h0);
    end
  end
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read while busy");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write while busy");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  bad_read_a: assert property (s_axi_arvalid && s_axi_arready &&
    ((s_axi_araddr > 8'h1c) || (s_axi_araddr[1:0] != 2'h0)) |=>
    s_axi_rresp == SRG_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read accepted");
  wr_resp_a: assert property ($rose(s_axi_bvalid) |->
    s_axi_bresp == (aw_bad_q ? SRG_RESP_SLVERR : SRG_RESP_OKAY)) else $error("wrong write resp");
  freeze_hold_a: assert property (digital_input_two && $past(digital_input_two) &&
    $past(digital_input_two, 2) && !$past(start_pulse) && !$past(start_pulse, 2) |->
    $stable(shaped_setpoint)) else $error("output moved while held");
endmodule
bind srg_top srg_top_sva srg_top_sva_inst (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .start_pulse, .digital_input_two, .shaped_setpoint);

// ### test/srg_drive_model.sv
`timescale 1ns/1ps
module srg_drive_model (
  // clock
  input wire logic clk,
  // setpoint sources
  output logic [15:0] target_setpoint,
  output logic start_pulse,
  output logic digital_input_two
);
  initial begin
    target_setpoint = 16'h0000;
    start_pulse = 1'b0;
    digital_input_two = 1'b0;
  end
  task automatic set_target(input logic [15:0] v);
    target_setpoint <= v;
  endtask
  task automatic set_hold(input logic h);
    digital_input_two <= h;
  endtask
  // one control cycle per enable, never stretched
  task automatic enable_drive();
    start_pulse <= 1'b1;
    @(posedge clk);
    start_pulse <= 1'b0;
  endtask
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb;
  import srg_pkg::*;
  // short tick keeps ramps quick; step per tick is unchanged
  localparam int TK = 64;
  logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic start_pulse, digital_input_two, slewing_flag;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, strb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] target_setpoint, shaped_setpoint, d, v;
  int n_mismatch, checks_done;
  srg_top #(.TICK_CYCLES(TK)) srg_top_inst (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .target_setpoint, .start_pulse,
    .digital_input_two, .shaped_setpoint, .slewing_flag);
  srg_drive_model srg_drive_model_inst (.clk, .target_setpoint, .start_pulse,
    .digital_input_two);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      aw = aw || s_axi_awready === 1'b1;
      w = w || s_axi_wready === 1'b1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
      s_axi_bready <= aw && w;
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", s_axi_bresp, er);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic taken;
    taken = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!taken) begin
      @(posedge clk);
      taken = s_axi_arready === 1'b1;
      s_axi_arvalid <= !taken;
      s_axi_rready <= taken;
    end
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wait_out(input logic [15:0] e, input int n);
    for (int i = 0; i < n && shaped_setpoint !== e; i++) @(posedge clk);
    chk("shaped", shaped_setpoint, e);
  endtask
  // delta between the second and third output values, skips a partial first move
  task automatic step(output logic [15:0] dl);
    logic [15:0] a;
    a = shaped_setpoint;
    for (int i = 0; i < 2*TK && shaped_setpoint === a; i++) @(posedge clk);
    a = shaped_setpoint;
    for (int i = 0; i < 2*TK && shaped_setpoint === a; i++) @(posedge clk);
    dl = shaped_setpoint - a;
  endtask
  task automatic t_regs();
    rd(SRG_OFF_CTRL, 32'(SRG_CTRL_RST), SRG_RESP_OKAY);
    rd(SRG_OFF_RISE, 32'(SRG_RISE_RST), SRG_RESP_OKAY);
    rd(SRG_OFF_FALL, 32'(SRG_FALL_RST), SRG_RESP_OKAY);
    rd(SRG_OFF_CURVE, 32'(SRG_CURVE_RST), SRG_RESP_OKAY);
    rd(SRG_OFF_LIMIT, 32'(SRG_LIMIT_RST), SRG_RESP_OKAY);
    rd(SRG_OFF_PRELOAD, 32'(SRG_PRELOAD_RST), SRG_RESP_OKAY);
    rd(SRG_OFF_OUTPUT, 32'h0, SRG_RESP_OKAY);
    rd(8'h20, 32'h0, SRG_RESP_SLVERR);
    wr(8'h22, 32'h5, SRG_RESP_SLVERR);
    strb = 4'h2;
    wr(SRG_OFF_PRELOAD, 32'h0000ab12, SRG_RESP_OKAY);
    strb = 4'hf;
    rd(SRG_OFF_PRELOAD, 32'h0000ab00, SRG_RESP_OKAY);
    wr(SRG_OFF_PRELOAD, 32'h0, SRG_RESP_OKAY);
  endtask
  task automatic t_ramp();
    wr(SRG_OFF_RISE, 32'h0, SRG_RESP_OKAY);
    rd(SRG_OFF_RISE, 32'(SRG_TIME_MIN), SRG_RESP_OKAY);
    wr(SRG_OFF_FALL, 32'h2, SRG_RESP_OKAY);
    wr(SRG_OFF_CURVE, 32'h0, SRG_RESP_OKAY);
    repeat (2*TK) @(posedge clk);
    srg_drive_model_inst.set_target(16'd1000);
    step(d);
    chk("rise step", d, 32'd100);
    chk("slewing", slewing_flag, 1'b1);
    rd(SRG_OFF_STATUS, 32'h3, SRG_RESP_OKAY);
    wait_out(16'd1000, 12*TK);
    repeat (3) @(posedge clk);
    chk("slewing", slewing_flag, 1'b0);
    rd(SRG_OFF_STATUS, 32'h0, SRG_RESP_OKAY);
    srg_drive_model_inst.set_target(16'd0);
    step(d);
    chk("fall step", d, 32'hffce);
    wait_out(16'd0, 24*TK);
  endtask
  task automatic t_freeze();
    srg_drive_model_inst.set_target(16'd1000);
    repeat (3*TK) @(posedge clk);
    srg_drive_model_inst.set_hold(1'b1);
    repeat (4) @(posedge clk);
    v = shaped_setpoint;
    srg_drive_model_inst.set_target(16'hfc18);
    repeat (5*TK) @(posedge clk);
    chk("held", shaped_setpoint, v);
    srg_drive_model_inst.set_hold(1'b0);
    step(d);
    chk("resume step", d, 32'hffce);
    wait_out(16'hfc18, 24*TK);
    repeat (3) @(posedge clk);
    chk("slewing", slewing_flag, 1'b0);
    rd(SRG_OFF_OUTPUT, 32'hfffffc18, SRG_RESP_OKAY);
    wr(SRG_OFF_CTRL, 32'ha, SRG_RESP_OKAY);
    srg_drive_model_inst.set_target(16'd0);
    repeat (3*TK) @(posedge clk);
    chk("held ctrl", shaped_setpoint, 32'h0000fc18);
    wr(SRG_OFF_CTRL, 32'h2, SRG_RESP_OKAY);
  endtask
  task automatic t_preload();
    wr(SRG_OFF_PRELOAD, 32'd300, SRG_RESP_OKAY);
    wr(SRG_OFF_CTRL, 32'hc, SRG_RESP_OKAY);
    repeat (4) @(posedge clk);
    chk("forced", shaped_setpoint, 32'd300);
    wr(SRG_OFF_CTRL, 32'h2, SRG_RESP_OKAY);
    step(d);
    chk("after forced", d, 32'hffce);
    srg_drive_model_inst.set_hold(1'b1);
    repeat (4) @(posedge clk);
    srg_drive_model_inst.enable_drive();
    repeat (3) @(posedge clk);
    chk("restart", shaped_setpoint, 32'd300);
    wr(SRG_OFF_CTRL, 32'h0, SRG_RESP_OKAY);
    wr(SRG_OFF_PRELOAD, 32'd500, SRG_RESP_OKAY);
    srg_drive_model_inst.enable_drive();
    repeat (3) @(posedge clk);
    chk("no restart", shaped_setpoint, 32'd300);
    srg_drive_model_inst.set_hold(1'b0);
    wr(SRG_OFF_CTRL, 32'h2, SRG_RESP_OKAY);
  endtask
  task automatic t_invert();
    wr(SRG_OFF_CTRL, 32'h3, SRG_RESP_OKAY);
    srg_drive_model_inst.set_target(16'd500);
    wait_out(16'hfe0c, 30*TK);
    wr(SRG_OFF_CURVE, 32'hffff, SRG_RESP_OKAY);
    rd(SRG_OFF_CURVE, 32'(SRG_PCT_MAX), SRG_RESP_OKAY);
    // output rests at target, so the new target starts the rate from zero
    repeat (2*TK) @(posedge clk);
    wr(SRG_OFF_CTRL, 32'h2, SRG_RESP_OKAY);
    step(d);
    chk("s start", d > 16'd0 && d < 16'd8, 1'b1);
    repeat (40*TK) @(posedge clk);
    step(d);
    chk("s linear", d == 16'd11 || d == 16'd12, 1'b1);
    wait_out(16'd500, 80*TK);
  endtask
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    strb = 4'hf;
    n_mismatch = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_ramp();
    t_freeze();
    t_preload();
    t_invert();
    end_of_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
